// ---- hw/sfr_core_ctrl.sv ----
/*
 Core-side end: an AHB-Lite slave that turns software commands into
 accesses on the special-function-register path, issuing the two key
 writes and the protected write back to back for an unlocked write.
 Assumes a single AHB-Lite master doing whole-word single transfers.
*/
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module sfr_core_ctrl
	import pwm_lock_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Access path
	sfr_link_if.core link
);
	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_KEY1 = 3'b001,
		SEQ_KEY2 = 3'b010,
		SEQ_TARGET = 3'b011,
		SEQ_READ = 3'b100
	} seq_state_type;

	seq_state_type seq_reg, seq_next;
	logic [SFR_AW-1:0] addr_reg, addr_next;
	logic [SFR_DW-1:0] data_reg, data_next;
	logic [1:0] cmd_reg, cmd_next;
	logic [SFR_DW-1:0] rd_reg, rd_next;
	logic refused_reg, refused_next;
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_off_reg, wr_off_next;
	logic [7:0] rd_off;
	logic busy;

	assign busy = seq_reg != SEQ_IDLE;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rd_off = haddr[7:0];

	logic [31:0] rdata_reg, rdata_next;

	// Read data is registered at the address phase and stands through the data phase
	assign hrdata = rdata_reg;

	always_comb begin
		seq_next = seq_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		cmd_next = cmd_reg;
		rd_next = rd_reg;
		refused_next = refused_reg;
		wr_pend_next = 1'b0;
		wr_off_next = wr_off_reg;
		rdata_next = rdata_reg;
		link.access = 1'b0;
		link.write = 1'b0;
		link.addr = addr_reg;
		link.wdata = data_reg;
		if (hsel && hready && htrans[1]) begin
			wr_pend_next = hwrite;
			wr_off_next = haddr[7:0];
			if (!hwrite) begin
				unique case (rd_off)
					CMD_ADDR_OFFSET: rdata_next = {24'h000000, addr_reg};
					CMD_DATA_OFFSET: rdata_next = {16'h0000, data_reg};
					STATUS_OFFSET: rdata_next = {30'h0, refused_reg, busy};
					READ_DATA_OFFSET: rdata_next = {16'h0000, rd_reg};
					default: rdata_next = '0;
				endcase
			end
		end
		if (wr_pend_reg) begin
			unique case (wr_off_reg)
				CMD_ADDR_OFFSET: addr_next = hwdata[SFR_AW-1:0];
				CMD_DATA_OFFSET: data_next = hwdata[SFR_DW-1:0];
				CMD_GO_OFFSET: begin
					// Software must not issue a command while busy; the status bit tells it
					if (!busy) begin
						cmd_next = hwdata[1:0];
						refused_next = 1'b0;
						unique case (hwdata[1:0])
							CMD_UNLOCKED_WRITE: seq_next = SEQ_KEY1;
							CMD_PLAIN_READ: seq_next = SEQ_READ;
							default: seq_next = SEQ_TARGET;
						endcase
					end
				end
				default: ;
			endcase
		end
		// Key and target accesses go out on consecutive cycles, nothing between
		unique case (seq_reg)
			SEQ_IDLE: ;
			SEQ_KEY1: begin
				link.access = 1'b1;
				link.write = 1'b1;
				link.addr = KEY_REG_ADDR;
				link.wdata = UNLOCK_KEY_FIRST;
				seq_next = SEQ_KEY2;
			end
			SEQ_KEY2: begin
				link.access = 1'b1;
				link.write = 1'b1;
				link.addr = KEY_REG_ADDR;
				link.wdata = UNLOCK_KEY_SECOND;
				seq_next = SEQ_TARGET;
			end
			SEQ_TARGET: begin
				link.access = 1'b1;
				link.write = 1'b1;
				if (cmd_reg == CMD_RAW_KEY) begin
					link.addr = KEY_REG_ADDR;
				end
				seq_next = SEQ_READ;
			end
			SEQ_READ: begin
				if (cmd_reg == CMD_PLAIN_READ) begin
					link.access = 1'b1;
				end
				seq_next = SEQ_IDLE;
			end
			default: seq_next = SEQ_IDLE;
		endcase
		// Results land one cycle after their access
		if (seq_reg == SEQ_READ) begin
			refused_next = refused_reg | link.refused;
		end
		if (seq_reg == SEQ_IDLE && cmd_reg == CMD_PLAIN_READ) begin
			rd_next = link.rdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_reg <= SEQ_IDLE;
			addr_reg <= '0;
			data_reg <= '0;
			cmd_reg <= CMD_PLAIN_WRITE;
			rd_reg <= '0;
			refused_reg <= 1'b0;
			wr_pend_reg <= 1'b0;
			wr_off_reg <= '0;
			rdata_reg <= '0;
		end else begin
			seq_reg <= seq_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			cmd_reg <= cmd_next;
			rd_reg <= rd_next;
			refused_reg <= refused_next;
			wr_pend_reg <= wr_pend_next;
			wr_off_reg <= wr_off_next;
			rdata_reg <= rdata_next;
		end
	end
endmodule : sfr_core_ctrl

// ---- hw/pwm_lock_pkg.sv ----
/*
 Constants shared by both ends of the PWM register write lock: key values,
 register offsets on the special-function-register path, reset values and
 the map of the controller's own AHB-Lite registers.
 Assumes 16-bit special-function-register data and word-aligned AHB access.
*/
package pwm_lock_pkg;
	localparam int SFR_AW = 8;
	localparam int SFR_DW = 16;
	localparam logic [SFR_DW-1:0] UNLOCK_KEY_FIRST = 16'hABCD;
	localparam logic [SFR_DW-1:0] UNLOCK_KEY_SECOND = 16'h4321;
	// Offsets on the access path
	localparam logic [SFR_AW-1:0] KEY_REG_ADDR = 8'h00;
	localparam logic [SFR_AW-1:0] OUTPUT_CONTROL_ADDR = 8'h02;
	localparam logic [SFR_AW-1:0] FAULT_LIMIT_ADDR = 8'h04;
	localparam logic [SFR_AW-1:0] OTHER_SFR_ADDR = 8'h06;
	localparam logic [SFR_DW-1:0] OUTPUT_CONTROL_RESET = 16'h0000;
	localparam logic [SFR_DW-1:0] FAULT_LIMIT_RESET = 16'h0000;
	localparam logic LOCK_CONFIG_DEFAULT = 1'b1;
	// Controller AHB-Lite register map (byte addresses)
	localparam logic [7:0] CMD_ADDR_OFFSET = 8'h00;
	localparam logic [7:0] CMD_DATA_OFFSET = 8'h04;
	localparam logic [7:0] CMD_GO_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0C;
	localparam logic [7:0] READ_DATA_OFFSET = 8'h10;
	// Command codes written to the go register
	localparam logic [1:0] CMD_PLAIN_WRITE = 2'h0;
	localparam logic [1:0] CMD_PLAIN_READ = 2'h1;
	localparam logic [1:0] CMD_UNLOCKED_WRITE = 2'h2;
	localparam logic [1:0] CMD_RAW_KEY = 2'h3;
endpackage : pwm_lock_pkg

// ---- hw/sfr_link_if.sv ----
/*
 Special-function-register access path between the core-side controller
 and the PWM lock device. One access per cycle, write or read.
 Assumes both ends share hclk.
*/
`timescale 1ns/1ps
interface sfr_link_if;
	import pwm_lock_pkg::*;
	logic access;
	logic write;
	logic [SFR_AW-1:0] addr;
	logic [SFR_DW-1:0] wdata;
	logic [SFR_DW-1:0] rdata;
	logic refused;
	modport core (output access, output write, output addr, output wdata,
		input rdata, input refused);
	modport device (input access, input write, input addr, input wdata,
		output rdata, output refused);
endinterface : sfr_link_if

// ---- hw/pwm_write_lock.sv ----
/*
 PWM write lock: the device end. Holds the output-control and fault/limit
 control registers and gates writes to them with the two-key unlock.
 Assumes the access path of sfr_link_if and a static lock config bit.
*/
`timescale 1ns/1ps
module pwm_write_lock
	import pwm_lock_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Configuration
	input wire logic pwm_write_lock_config_bit,
	// Access path
	sfr_link_if.device link,
	// Register contents to the PWM generator
	output logic [SFR_DW-1:0] pwm_output_control_reg,
	output logic [SFR_DW-1:0] pwm_fault_limit_control_reg,
	output logic unlocked
);
	typedef enum logic [1:0] {
		LOCK_IDLE = 2'b00,
		LOCK_KEY1 = 2'b01,
		LOCK_OPEN = 2'b10
	} lock_state_type;

	lock_state_type state_reg, state_next;
	logic [SFR_DW-1:0] out_ctl_next, fault_next;
	logic [SFR_DW-1:0] rdata_reg, rdata_next;
	logic refused_reg, refused_next;
	logic protected_hit;

	assign protected_hit = link.addr == OUTPUT_CONTROL_ADDR || link.addr == FAULT_LIMIT_ADDR;
	assign link.rdata = rdata_reg;
	assign link.refused = refused_reg;
	assign unlocked = state_reg == LOCK_OPEN;

	always_comb begin
		state_next = state_reg;
		out_ctl_next = pwm_output_control_reg;
		fault_next = pwm_fault_limit_control_reg;
		rdata_next = rdata_reg;
		refused_next = 1'b0;
		if (link.access) begin
			// Any access moves the tracker; only the expected one advances it
			unique case (state_reg)
				LOCK_IDLE: begin
					if (link.write && link.addr == KEY_REG_ADDR &&
						link.wdata == UNLOCK_KEY_FIRST) begin
						state_next = LOCK_KEY1;
					end
				end
				LOCK_KEY1: begin
					if (link.write && link.addr == KEY_REG_ADDR &&
						link.wdata == UNLOCK_KEY_SECOND) begin
						state_next = LOCK_OPEN;
					end else begin
						state_next = LOCK_IDLE;
					end
				end
				LOCK_OPEN: begin
					state_next = LOCK_IDLE;
				end
				default: begin
					state_next = LOCK_IDLE;
				end
			endcase
			if (link.write && protected_hit) begin
				if (!pwm_write_lock_config_bit || state_reg == LOCK_OPEN) begin
					if (link.addr == OUTPUT_CONTROL_ADDR) begin
						out_ctl_next = link.wdata;
					end else begin
						fault_next = link.wdata;
					end
				end else begin
					refused_next = 1'b1;
				end
			end
			if (!link.write) begin
				unique case (link.addr)
					OUTPUT_CONTROL_ADDR: rdata_next = pwm_output_control_reg;
					FAULT_LIMIT_ADDR: rdata_next = pwm_fault_limit_control_reg;
					default: rdata_next = '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= LOCK_IDLE;
			pwm_output_control_reg <= OUTPUT_CONTROL_RESET;
			pwm_fault_limit_control_reg <= FAULT_LIMIT_RESET;
			rdata_reg <= '0;
			refused_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pwm_output_control_reg <= out_ctl_next;
			pwm_fault_limit_control_reg <= fault_next;
			rdata_reg <= rdata_next;
			refused_reg <= refused_next;
		end
	end
endmodule : pwm_write_lock

// ---- tb/pwm_lock_monitor.sv ----
/* Checker of the unlock path between the two ends.
 Assumes one clock; watches the link, the config bit and the unlocked flag. */
`timescale 1ns/1ps
module pwm_lock_monitor
	import pwm_lock_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Watched signals
	input wire logic pwm_write_lock_config_bit,
	input wire logic access,
	input wire logic write,
	input wire logic [SFR_AW-1:0] addr,
	input wire logic [SFR_DW-1:0] wdata,
	input wire logic refused,
	input wire logic unlocked
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic first_reg;
	logic first_next;
	wire key_wr = access && write && addr == KEY_REG_ADDR;
	wire pair = key_wr && wdata == UNLOCK_KEY_SECOND && first_reg;
	wire prot = access && write && (addr == OUTPUT_CONTROL_ADDR || addr == FAULT_LIMIT_ADDR);
	// Idle cycles are not accesses, so the tracker only moves on access.
	// A first key only counts from the locked idle state; an open unlock is simply consumed.
	always_comb first_next = access ?
		key_wr && wdata == UNLOCK_KEY_FIRST && !first_reg && !unlocked : first_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) first_reg <= 1'b0;
		else first_reg <= first_next;
	end
	sequence pair_done; pair; endsequence
	sequence prot_locked; prot && pwm_write_lock_config_bit && !unlocked; endsequence
	a_pair_opens: assert property (pair_done |=> unlocked)
		else $error("key pair did not unlock");
	a_other_closes: assert property (access && !pair |=> !unlocked)
		else $error("unlock survived an access");
	a_idle_holds: assert property (unlocked && !access |=> unlocked)
		else $error("unlock lost without access");
	a_locked_refuse: assert property (prot_locked |=> refused)
		else $error("locked write not refused");
	a_open_accepts: assert property (prot && unlocked |=> !refused)
		else $error("unlocked write refused");
	a_config_free: assert property (prot && !pwm_write_lock_config_bit |=> !refused)
		else $error("write refused with lock off");
	a_refuse_cause: assert property (refused |-> $past(prot))
		else $error("refusal without protected write");
endmodule : pwm_lock_monitor

// ---- tb/test_pwm_register_write_lock.sv ----
/* Bench: an AHB-Lite master drives the controller, which drives the lock.
 Assumes the command map and status layout of the controller. */
`timescale 1ns/1ps
module test_pwm_register_write_lock
	import pwm_lock_pkg::*;
;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, lock_cfg = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, got;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, unlocked;
	logic [15:0] oc, fl, d, q[$];
	logic [15:0] oc_pin, fl_pin;
	int fail_count = 0, n_tests = 0, cyc = 0;
	event rd_ev;
	sfr_link_if link();
	pwm_write_lock pwm_write_lock_i(.hclk(hclk), .hresetn(hresetn),
		.pwm_write_lock_config_bit(lock_cfg), .link(link), .pwm_output_control_reg(oc_pin),
		.pwm_fault_limit_control_reg(fl_pin), .unlocked(unlocked));
	sfr_core_ctrl sfr_core_ctrl_i(.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link));
	pwm_lock_monitor pwm_lock_monitor_i(.hclk(hclk), .hresetn(hresetn),
		.pwm_write_lock_config_bit(lock_cfg), .access(link.access), .write(link.write),
		.addr(link.addr), .wdata(link.wdata), .refused(link.refused), .unlocked(unlocked));
	always #5 hclk = ~hclk;
	task summarize;
		$display("tests %0d fails %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize
	// Hang guard: a full run needs a few hundred cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end
	task compare(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			fail_count++;
			$display("[FAIL] %0t mismatch %h expected %h", $time, seen, want);
		end
	endtask : compare
	// Each read result is held against the oldest note
	always @(rd_ev) begin
		compare(got[15:0], q.pop_front());
	end
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1);
		hsel <= 0;
		htrans <= 0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1);
		r = hrdata;
	endtask : ahb
	task expect_rd(input logic [7:0] a, input logic [15:0] e);
		q.push_back(e);
		ahb(0, a, 0, got);
		-> rd_ev;
	endtask : expect_rd
	task cmd(input logic [1:0] c, input logic [7:0] a, input logic [15:0] v);
		logic [31:0] r;
		ahb(1, CMD_ADDR_OFFSET, {24'h0, a}, r);
		ahb(1, CMD_DATA_OFFSET, {16'h0, v}, r);
		ahb(1, CMD_GO_OFFSET, {30'h0, c}, r);
		do ahb(0, STATUS_OFFSET, 0, r); while (r[0] !== 0);
	endtask : cmd
	task wr(input logic [1:0] c, input logic [7:0] a, input logic [15:0] v, input logic rf);
		cmd(c, a, v);
		expect_rd(STATUS_OFFSET, {14'h0, rf, 1'b0});
	endtask : wr
	task chk_sfr(input logic [7:0] a, input logic [15:0] e);
		cmd(CMD_PLAIN_READ, a, 0);
		expect_rd(READ_DATA_OFFSET, e);
	endtask : chk_sfr
	initial begin
		void'($urandom(5));
		repeat (3) @(posedge hclk);
		hresetn <= 1;
		chk_sfr(OUTPUT_CONTROL_ADDR, OUTPUT_CONTROL_RESET);
		chk_sfr(FAULT_LIMIT_ADDR, FAULT_LIMIT_RESET);
		wr(CMD_PLAIN_WRITE, OUTPUT_CONTROL_ADDR, 16'($urandom), 1);
		oc = 16'($urandom);
		fl = 16'($urandom);
		wr(CMD_UNLOCKED_WRITE, OUTPUT_CONTROL_ADDR, oc, 0);
		wr(CMD_UNLOCKED_WRITE, FAULT_LIMIT_ADDR, fl, 0);
		// An access between the keys and the write spoils the unlock
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, UNLOCK_KEY_FIRST);
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, UNLOCK_KEY_SECOND);
		wr(CMD_PLAIN_WRITE, OTHER_SFR_ADDR, 16'($urandom), 0);
		wr(CMD_PLAIN_WRITE, OUTPUT_CONTROL_ADDR, 16'($urandom), 1);
		d = 16'($urandom);
		if (d == UNLOCK_KEY_SECOND) d = ~d;
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, UNLOCK_KEY_FIRST);
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, d);
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, UNLOCK_KEY_SECOND);
		wr(CMD_PLAIN_WRITE, FAULT_LIMIT_ADDR, 16'($urandom), 1);
		oc = 16'($urandom);
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, UNLOCK_KEY_FIRST);
		cmd(CMD_RAW_KEY, KEY_REG_ADDR, UNLOCK_KEY_SECOND);
		wr(CMD_PLAIN_WRITE, OUTPUT_CONTROL_ADDR, oc, 0);
		wr(CMD_PLAIN_WRITE, FAULT_LIMIT_ADDR, 16'($urandom), 1);
		chk_sfr(OUTPUT_CONTROL_ADDR, oc);
		lock_cfg <= 0;
		fl = 16'($urandom);
		wr(CMD_PLAIN_WRITE, FAULT_LIMIT_ADDR, fl, 0);
		chk_sfr(FAULT_LIMIT_ADDR, fl);
		compare(oc_pin, oc);
		compare(fl_pin, fl);
		summarize();
	end
endmodule : test_pwm_register_write_lock
